// ### short_io_map.svh
`ifndef SHORT_IO_MAP_SVH
`define SHORT_IO_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define REG_STRAP_REPORT  8'h00
`define REG_STRAP_STATUS  8'h04
`define REG_CONTROL       8'h08
`define REG_HIT_COUNT     8'h0c
`define REG_REJECT_COUNT  8'h10
`define REG_LAST_CYCLE    8'h14

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define REPORT_FIXED      27'h0000000
`define CONTROL_RESET     1'h1
`define CTRL_ENABLE_BIT   0
`define CTRL_CLEAR_BIT    1
`define STAT_BASE_LSB     0
`define STAT_CLASS_LSB    8
`define STAT_SCAN_LSB     10
`define STAT_TIMER_LSB    17
`define AM_SHORT_SUPER    6'h2d
`define AM_SHORT_NONPRIV  6'h29

`endif

// ### short_io_pkg.sv
package short_io_pkg;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ACC_SUPER   = 2'h0,
      ACC_EITHER  = 2'h1,
      ACC_NONPRIV = 2'h2
   } access_e;

   typedef enum logic [1:0] {
      CYC_IDLE   = 2'h0,
      CYC_SELECT = 2'h1,
      CYC_WAIT   = 2'h3
   } cycle_e;

   typedef struct packed {
      logic [15:1] addr;
      logic [5:0]  am;
      logic        strobe;
   } bus_cycle_s;

   typedef struct packed {
      logic [9:0] base_access;
      logic [6:0] scan_len;
      logic [4:0] report;
      logic [2:0] timer;
   } strap_s;

   typedef struct packed {
      logic [31:0] wdata;
      logic [7:0]  addr;
      logic        wr;
      logic        rd;
   } reg_req_s;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta  <= '0;
         level <= '0;
      end else begin
         meta  <= pin;
         level <= meta;
      end
   end

endmodule

// ### short_io_decoder.sv
`timescale 1ns/1ps
`include "short_io_map.svh"

module short_io_decoder (
   input  wire logic                    mclk,
   input  wire logic                    rst,
   // bus cycle pins
   input  wire logic [15:1]             bus_addr,
   input  wire logic [5:0]              bus_am,
   input  wire logic                    bus_strobe_n,
   // strap pins, pulled up, fitted plug reads low
   input  wire logic [9:0]              base_and_access_straps,
   input  wire logic [6:0]              scan_length_straps,
   input  wire logic [4:0]              config_report_straps,
   input  wire logic [2:0]              timer_chain_straps,
   // register port
   input  wire short_io_pkg::reg_req_s  reg_req,
   output logic [31:0]                  reg_rdata,
   // decode results
   output logic                         board_select,
   output logic [6:0]                   reg_word,
   output logic                         select_nonpriv,
   output logic                         class_reject,
   // strap options to scan and timer logic
   output logic [6:0]                   scan_channels,
   output logic                         counter_first_starts_conv,
   output logic                         counter_first_to_second,
   output logic                         counter_second_to_third
);

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   localparam int PIN_W = 15 + 6 + 1 + 10 + 7 + 5 + 3;

   logic [PIN_W-1:0] pin_level;
   short_io_pkg::bus_cycle_s cyc;
   short_io_pkg::strap_s     straps;

   // straps share the same two-flop path as the bus pins
   pin_sync #(
      .WIDTH (PIN_W)
   ) u_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   ({bus_addr, bus_am, ~bus_strobe_n, base_and_access_straps,
               scan_length_straps, config_report_straps, timer_chain_straps}),
      .level (pin_level)
   );

   assign cyc    = pin_level[PIN_W-1 -: 22];
   assign straps = pin_level[24:0];

   // ----------------------------------------
   // strap interpretation
   // ----------------------------------------
   // plug fitted pulls the line low, so the level is the bit value
   wire [7:0] base_bits = straps.base_access[7:0];
   wire       either_fitted  = ~straps.base_access[8];
   wire       nonpriv_fitted = ~straps.base_access[9];

   function automatic short_io_pkg::access_e decode_access(input logic either, input logic nonpriv);
      if (either)
         return short_io_pkg::ACC_EITHER;
      else if (nonpriv)
         return short_io_pkg::ACC_NONPRIV;
      else
         return short_io_pkg::ACC_SUPER;
   endfunction

   short_io_pkg::access_e access_mode;
   assign access_mode = decode_access(either_fitted, nonpriv_fitted);

   // all plugs fitted except scan msb gives base 0, both classes, 64 channels
   wire [6:0] scan_bits = straps.scan_len;
   // a fitted timer plug enables its option
   wire [2:0] timer_en  = ~straps.timer;

   // ----------------------------------------
   // cycle classification
   // ----------------------------------------
   wire am_super   = (cyc.am == `AM_SHORT_SUPER);
   wire am_nonpriv = (cyc.am == `AM_SHORT_NONPRIV);
   wire short_io   = am_super | am_nonpriv;

   function automatic logic class_allowed(input short_io_pkg::access_e mode,
                                          input logic sup, input logic npr);
      unique case (mode)
         short_io_pkg::ACC_EITHER:  return sup | npr;
         short_io_pkg::ACC_NONPRIV: return npr;
         short_io_pkg::ACC_SUPER:   return sup;
         default:                   return 1'b0;
      endcase
   endfunction

   wire base_match = (cyc.addr[15:8] == base_bits);
   wire class_ok   = class_allowed(access_mode, am_super, am_nonpriv);

   logic decode_enable;
   wire  start_cycle = cyc.strobe & decode_enable & short_io & base_match;
   wire  hit         = start_cycle & class_ok;
   wire  miss_class  = start_cycle & ~class_ok;

   // ----------------------------------------
   // cycle state machine
   // ----------------------------------------
   short_io_pkg::cycle_e state;
   short_io_pkg::cycle_e next_state;

   always_comb begin
      next_state = state;
      unique case (state)
         short_io_pkg::CYC_IDLE: begin
            if (hit)
               next_state = short_io_pkg::CYC_SELECT;
            else if (miss_class)
               next_state = short_io_pkg::CYC_WAIT;
         end
         short_io_pkg::CYC_SELECT: begin
            if (!cyc.strobe)
               next_state = short_io_pkg::CYC_IDLE;
         end
         short_io_pkg::CYC_WAIT: begin
            if (!cyc.strobe)
               next_state = short_io_pkg::CYC_IDLE;
         end
         default: next_state = short_io_pkg::CYC_IDLE;
      endcase
   end

   wire idle      = (state == short_io_pkg::CYC_IDLE);
   wire take_hit  = idle & hit;
   wire take_miss = idle & miss_class;

   always_ff @(posedge mclk) begin
      if (rst)
         state <= short_io_pkg::CYC_IDLE;
      else
         state <= next_state;
   end

   // a rejected cycle never raises select, it only pulses the reject flag
   always_ff @(posedge mclk) begin
      if (rst) begin
         board_select   <= 1'b0;
         reg_word       <= 7'h00;
         select_nonpriv <= 1'b0;
         class_reject   <= 1'b0;
      end else begin
         board_select   <= (next_state == short_io_pkg::CYC_SELECT);
         class_reject   <= take_miss;
         if (take_hit) begin
            reg_word       <= cyc.addr[7:1];
            select_nonpriv <= am_nonpriv;
         end
      end
   end

   // ----------------------------------------
   // strap option outputs
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         scan_channels             <= 7'h00;
         counter_first_starts_conv <= 1'b0;
         counter_first_to_second   <= 1'b0;
         counter_second_to_third   <= 1'b0;
      end else begin
         scan_channels             <= scan_bits;
         counter_first_starts_conv <= timer_en[2];
         counter_first_to_second   <= timer_en[1];
         counter_second_to_third   <= timer_en[0];
      end
   end

   // ----------------------------------------
   // register port
   // ----------------------------------------
   logic [15:0] hit_count;
   logic [15:0] reject_count;
   logic [8:0]  last_cycle;

   wire wr_control = reg_req.wr & (reg_req.addr == `REG_CONTROL);
   wire clear_cnt  = wr_control & reg_req.wdata[`CTRL_CLEAR_BIT];

   always_ff @(posedge mclk) begin
      if (rst)
         decode_enable <= `CONTROL_RESET;
      else if (wr_control)
         decode_enable <= reg_req.wdata[`CTRL_ENABLE_BIT];
   end

   // an event in the clearing cycle is kept, so the count restarts at one
   always_ff @(posedge mclk) begin
      if (rst) begin
         hit_count    <= 16'h0000;
         reject_count <= 16'h0000;
      end else begin
         if (clear_cnt)
            hit_count <= {15'h0000, take_hit};
         else if (take_hit)
            hit_count <= hit_count + 16'h0001;
         if (clear_cnt)
            reject_count <= {15'h0000, take_miss};
         else if (take_miss)
            reject_count <= reject_count + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst)
         last_cycle <= 9'h000;
      else if (take_hit | take_miss)
         last_cycle <= {take_miss, am_nonpriv, cyc.addr[7:1]};
   end

   wire [31:0] report_word = {`REPORT_FIXED, straps.report};

   wire [31:0] status_word = {12'h000, timer_en, scan_bits, access_mode, base_bits};

   logic [31:0] read_mux;
   always_comb begin
      unique case (reg_req.addr)
         `REG_STRAP_REPORT: read_mux = report_word;
         `REG_STRAP_STATUS: read_mux = status_word;
         `REG_CONTROL:      read_mux = {31'h00000000, decode_enable};
         `REG_HIT_COUNT:    read_mux = {16'h0000, hit_count};
         `REG_REJECT_COUNT: read_mux = {16'h0000, reject_count};
         `REG_LAST_CYCLE:   read_mux = {23'h000000, last_cycle};
         default:           read_mux = 32'h00000000;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (rst)
         reg_rdata <= 32'h00000000;
      else if (reg_req.rd)
         reg_rdata <= read_mux;
      else
         reg_rdata <= 32'h00000000;
   end

endmodule

// ### host_bus_model.sv
`timescale 1ns/1ps
// ----
// host board driving short i/o cycles
// ----
module host_bus_model (
   input  wire logic        mclk,
   output logic      [15:1] bus_addr,
   output logic      [5:0]  bus_am,
   output logic             bus_strobe_n
);
   initial begin
      bus_addr = 15'h0000;
      bus_am = 6'h00;
      bus_strobe_n = 1'b1;
   end
   // address and modifier held for the whole strobe
   task automatic start(input logic [15:0] a, input logic [5:0] am);
      @(posedge mclk);
      bus_addr <= a[15:1];
      bus_am <= am;
      bus_strobe_n <= 1'b0;
   endtask
   // released lines flip, so a stale value cannot match
   task automatic stop();
      @(posedge mclk);
      bus_strobe_n <= 1'b1;
      bus_addr <= ~bus_addr;
      bus_am <= ~bus_am;
   endtask
endmodule

// ### short_io_decoder_asserts.sv
`timescale 1ns/1ps
module short_io_decoder_asserts (
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic [15:1]            bus_addr,
   input wire logic [5:0]             bus_am,
   input wire logic                   bus_strobe_n,
   input wire logic [9:0]             base_and_access_straps,
   input wire logic [6:0]             scan_length_straps,
   input wire short_io_pkg::reg_req_s reg_req,
   input wire logic [31:0]            reg_rdata,
   input wire logic                   board_select,
   input wire logic [6:0]             reg_word,
   input wire logic                   select_nonpriv,
   input wire logic                   class_reject,
   input wire logic [6:0]             scan_channels
);
   // ----
   // settle counter, sync pipe needs edges after reset
   // ----
   logic [2:0] up_cnt;
   always_ff @(posedge mclk) begin
      if (rst) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
      else $error("read data outside read slot");
   a_reject_pulse: assert property (class_reject |=> !class_reject)
      else $error("reject longer than one cycle");
   a_reject_excl: assert property (class_reject |-> !board_select)
      else $error("reject with select");
   a_select_strobe: assert property (board_select |-> !$past(bus_strobe_n, 3))
      else $error("select without strobe");
   a_select_base: assert property ($rose(board_select) |->
      $past(bus_addr[15:8], 3) == $past(base_and_access_straps[7:0], 3))
      else $error("select on base mismatch");
   a_select_word: assert property ($rose(board_select) |-> reg_word == $past(bus_addr[7:1], 3))
      else $error("wrong word address");
   a_select_class: assert property ($rose(board_select) |->
      (!$past(base_and_access_straps[8], 3) ||
       $past(bus_am, 3) == ($past(base_and_access_straps[9], 3) ? 6'h2d : 6'h29)))
      else $error("select in disabled class");
   a_nonpriv_flag: assert property (board_select && $past(board_select) |->
      select_nonpriv == ($past(bus_am, 3) == 6'h29))
      else $error("wrong class flag");
   // two sync flops plus the output flop put the strap three edges behind
   a_scan_follow: assert property (up_cnt == 3'h7 |-> scan_channels == $past(scan_length_straps, 3))
      else $error("scan length not from straps");
endmodule

// ### short_io_slave_strap_decoder_bench.sv
`timescale 1ns/1ps
module short_io_slave_strap_decoder_bench;
   logic                   mclk;
   logic                   rst;
   logic [15:1]            bus_addr;
   logic [5:0]             bus_am;
   logic                   bus_strobe_n;
   logic [9:0]             base_and_access_straps;
   logic [6:0]             scan_length_straps;
   logic [4:0]             config_report_straps;
   logic [2:0]             timer_chain_straps;
   short_io_pkg::reg_req_s reg_req;
   logic [31:0]            reg_rdata;
   logic                   board_select;
   logic [6:0]             reg_word;
   logic                   select_nonpriv;
   logic                   class_reject;
   logic [6:0]             scan_channels;
   wire  [2:0]             tmr;
   logic                   sel_seen;
   logic                   rej_seen;
   int                     fail_count;
   int                     cmp_count;
   logic [6:0]             scan_tab [3] = '{7'h10, 7'h25, 7'h7f};
   short_io_decoder uut (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_am(bus_am),
      .bus_strobe_n(bus_strobe_n), .base_and_access_straps(base_and_access_straps),
      .scan_length_straps(scan_length_straps), .config_report_straps(config_report_straps),
      .timer_chain_straps(timer_chain_straps), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .board_select(board_select), .reg_word(reg_word), .select_nonpriv(select_nonpriv),
      .class_reject(class_reject), .scan_channels(scan_channels), .counter_first_starts_conv(tmr[2]),
      .counter_first_to_second(tmr[1]), .counter_second_to_third(tmr[0]));
   host_bus_model bus (.mclk(mclk), .bus_addr(bus_addr), .bus_am(bus_am), .bus_strobe_n(bus_strobe_n));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // reject is a one-cycle pulse, so catch it here
   always @(posedge mclk) begin
      if (board_select) sel_seen <= 1'b1;
      if (class_reject) rej_seen <= 1'b1;
   end
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge mclk);
      reg_req <= '{32'h0, a, 1'b0, 1'b1};
      @(posedge mclk);
      reg_req.rd <= 1'b0;
      #1 check(nm, reg_rdata, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_req <= '{d, a, 1'b1, 1'b0};
      @(posedge mclk);
      reg_req.wr <= 1'b0;
   endtask
   task automatic cyc(input logic [15:0] a, input logic [5:0] am, input logic es, input logic er);
      sel_seen = 1'b0;
      rej_seen = 1'b0;
      bus.start(a, am);
      repeat (7) @(posedge mclk);
      #1 check("select", sel_seen, es);
      check("reject", rej_seen, er);
      if (es) check("word", reg_word, a[7:1]);
      if (es) check("nonpriv", select_nonpriv, am == 6'h29);
      bus.stop();
      repeat (5) @(posedge mclk);
      #1 check("release", board_select, 1'b0);
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      rst = 1'b1;
      reg_req = '0;
      base_and_access_straps = 10'h000;
      scan_length_straps = 7'h40;
      config_report_straps = 5'h00;
      timer_chain_straps = 3'h6;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 check("scan", scan_channels, 7'h40);
      check("timer", tmr, 3'h1);
      rd(8'h00, 32'h0, "report");
      rd(8'h04, 32'h0003_0100, "status");
      rd(8'h20, 32'h0, "unmapped");
      wr(8'h08, 32'h3);
      cyc(16'h00a6, 6'h2d, 1'b1, 1'b0);
      cyc(16'h00a6, 6'h29, 1'b1, 1'b0);
      cyc(16'h00a6, 6'h3d, 1'b0, 1'b0);
      cyc(16'h01a6, 6'h2d, 1'b0, 1'b0);
      rd(8'h0c, 32'h2, "hits");
      wr(8'h08, 32'h0);
      cyc(16'h00a6, 6'h2d, 1'b0, 1'b0);
      wr(8'h08, 32'h1);
      // access modes: super only, nonpriv only, either
      for (int m = 0; m < 3; m++) begin
         @(posedge mclk);
         base_and_access_straps <= {(m == 2) ? 2'b10 : (m == 1) ? 2'b01 : 2'b11, 8'h85};
         repeat (4) @(posedge mclk);
         cyc(16'h85fe, 6'h2d, m != 1, m == 1);
         cyc(16'h85fe, 6'h29, m != 0, m == 0);
      end
      cyc(16'h84fe, 6'h2d, 1'b0, 1'b0);
      cyc(16'h05fe, 6'h29, 1'b0, 1'b0);
      rd(8'h04, 32'h0003_0185, "status");
      rd(8'h0c, 32'h6, "hits");
      rd(8'h10, 32'h2, "rejects");
      rd(8'h14, 32'h0ff, "last");
      rd(8'h08, 32'h1, "control");
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         scan_length_straps <= scan_tab[i];
         timer_chain_straps <= i[2:0] + 3'h3;
         config_report_straps <= 5'h15 ^ i[4:0];
         repeat (4) @(posedge mclk);
         #1 check("scan", scan_channels, scan_tab[i]);
         check("timer", tmr, 3'(~(i[2:0] + 3'h3)));
         rd(8'h00, {27'h0, 5'h15 ^ i[4:0]}, "report");
      end
      results();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      results();
   end
endmodule
bind short_io_decoder short_io_decoder_asserts chk (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
   .bus_am(bus_am), .bus_strobe_n(bus_strobe_n), .base_and_access_straps(base_and_access_straps),
   .scan_length_straps(scan_length_straps), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .board_select(board_select), .reg_word(reg_word), .select_nonpriv(select_nonpriv),
   .class_reject(class_reject), .scan_channels(scan_channels));
